// ### verilog/cfxp_defs.svh
// named constants of the cpu frame extraction path
// assumes it is included by bare name from cfxp_top, the checker and the bench
`ifndef CFXP_DEFS_SVH
`define CFXP_DEFS_SVH

// register offsets on the plain register port
`define CFXP_REG_MAP 8'h00
`define CFXP_REG_CFG 8'h04
`define CFXP_REG_STAT 8'h08

// field positions inside the config register
`define CFXP_CFG_HDR_LSB 0
`define CFXP_CFG_RR_LSB 8

// field positions inside the status register
`define CFXP_STAT_P1_LSB 8

// reset values of the software registers
`define CFXP_MAP_RST 8'h00
`define CFXP_HDR_EN_RST 2'h0
`define CFXP_RR_RST 2'h0

// length encoding: bytes = words * 60 + remainder - 80
`define CFXP_LEN_UNIT 15'h003C
`define CFXP_LEN_BIAS 15'h0050

// rewrite operation code for two-step timing
`define CFXP_OP_TWO_STEP 3'h3

// customer tag protocol identifier
`define CFXP_TPID_CTAG 16'h8100

// sample origin codes
`define CFXP_SMP_RSV_LO 4'hD
`define CFXP_SMP_RSV_HI 4'hE
`define CFXP_SMP_NONE 4'hF

// last header word index (four 32-bit words)
`define CFXP_HDR_LAST 2'h3

`endif

// ### verilog/cfxp_pkg.sv
// types of the cpu frame extraction path
// assumes cfxp_defs.svh sits in the include path
`default_nettype none
package cfxp_pkg;

  // per-port frame state, one-hot
  typedef enum logic [3:0] {
    CFXP_S_IDLE = 4'h1,
    CFXP_S_META = 4'h2,
    CFXP_S_HDR = 4'h4,
    CFXP_S_DATA = 4'h8
  } cfxp_fsm_t;

  // side-band facts the switch core hands over with each frame
  typedef struct packed {
    logic two_step;
    logic [5:0] ts_id;
    logic [31:0] rx_time;
    logic [13:0] byte_len;
    logic [3:0] ingress_port_number;
    logic [5:0] rule_action_id;
    logic [3:0] sample_origin_id;
    logic copy_to_host_action;
    logic copy_once_action;
    logic drop_level;
    logic [1:0] learn_action_code;
    logic [7:0] queue_hit_mask;
    logic [2:0] service_class;
    logic [15:0] tpid;
    logic [2:0] tag_priority;
    logic drop_eligible;
    logic [11:0] vlan_number;
  } cfxp_meta_t;

  // extraction header, bit 127 down to bit 0
  typedef struct packed {
    logic [1:0] rsvd_top;
    logic [8:0] rewrite_op_code;
    logic [31:0] rx_time_value;
    logic [5:0] length_remainder;
    logic [7:0] length_word_count;
    logic [23:0] rsvd_mid;
    logic [3:0] ingress_port_number;
    logic [5:0] rule_action_id;
    logic rsvd_low;
    logic [3:0] sample_origin_id;
    logic rule_hit_flag;
    logic drop_level;
    logic [1:0] learn_action_code;
    logic [7:0] queue_hit_mask;
    logic [2:0] service_class;
    logic tag_type;
    logic [2:0] tag_priority;
    logic drop_eligible;
    logic [11:0] vlan_number;
  } cfxp_hdr_t;

  // state of one cpu port
  typedef struct packed {
    cfxp_fsm_t fsm;
    logic [1:0] cnt;
    logic [127:0] hdr;
    logic [31:0] out_data;
    logic out_valid;
    logic out_last;
    logic grant;
    logic [2:0] grant_q;
    logic core_ready;
  } cfxp_port_t;

  // whole state of the top module
  typedef struct packed {
    logic [7:0] map;
    logic [1:0] hdr_en;
    logic [1:0] rr_mode;
    logic [31:0] rdata;
    cfxp_port_t [1:0] port;
  } cfxp_state_t;

  // scheduler state: last queue served
  typedef struct packed {
    logic [2:0] last;
  } cfxp_sched_st_t;

endpackage : cfxp_pkg

`default_nettype wire

// ### verilog/cfxp_sched.sv
// per-port queue scheduler: strict priority or round robin over eight queues
// assumes take is high only in a cycle where any_out is high
`timescale 1ns/1ns
`default_nettype none

module cfxp_sched
  import cfxp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] req_in,
  input wire logic rr_mode_in,
  input wire logic take_in,
  output logic [2:0] pick_out,
  output logic any_out
);

  cfxp_sched_st_t st; // registered state
  cfxp_sched_st_t next_st; // next state
  logic [2:0] idx; // candidate queue in the rotating search
  logic found; // a candidate was found

  ////////////////////////////////////////////////////////////////////////
  // choose a queue and work out the pointer
  always_comb begin
    next_st = st;
    pick_out = 3'h0;
    found = 1'b0;
    idx = 3'h0;
    any_out = |req_in;
    if (rr_mode_in) begin
      // search upward from the queue after the last served, wrapping
      for (int i = 1; i <= 8; i++) begin
        idx = 3'(st.last + 3'(i));
        if (!found && req_in[idx]) begin
          pick_out = idx;
          found = 1'b1;
        end
      end
    end else begin
      // highest non-empty queue number wins
      for (int i = 0; i < 8; i++) begin
        if (req_in[i]) begin
          pick_out = 3'(i);
        end
      end
    end
    // remember what was served so the turn moves on
    if (take_in) begin
      next_st.last = pick_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register the state
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : cfxp_sched

`default_nettype wire

// ### verilog/cfxp_top.sv
// cpu frame extraction path: eight queues onto two cpu ports, optional header
// assumes the switch core streams a granted frame's side-band then its words
// How it works
// - each queue mapped to port 11 or 12
// - one scheduler per port, strict or round-robin
// - strict: higher non-empty queue number served first
// - round robin: mapped queues served in turn
// - header prepended when port's insert enable set
// - rewrite op at 117; code 3 two-step
// - receive time, 32 bits, at bit 85
// - length as remainder at 79, words at 71
// - receiving port, four bits, at bit 43
// - rule action id at 37, only on hit
// - sample origin at 32; 13, 14 reserved
// - bit 31 set on copy or copy-once hit
// - drop precedence level in bit 30
// - learning action code at bit 28
// - queue hit mask, eight bits, at 20
// - service class, three bits, at 17
// - bit 16: customer tag 0, else 1
// - priority at 13, eligible 12, vlan 0
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cfxp_defs.svh"

module cfxp_top
  import cfxp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // switch core: queue status and grants
  input wire logic [7:0] q_nonempty_in,
  output logic [1:0] grant_out,
  output logic [1:0][2:0] grant_queue_out,
  // switch core: side-band and frame words per cpu port
  input wire logic [1:0] meta_valid_in,
  input wire cfxp_meta_t [1:0] meta_in,
  input wire logic [1:0] core_valid_in,
  input wire logic [1:0][31:0] core_data_in,
  input wire logic [1:0] core_last_in,
  output logic [1:0] core_ready_out,
  // cpu system reader per cpu port (index 0 is port 11, 1 is port 12)
  output logic [1:0] rd_valid_out,
  output logic [1:0][31:0] rd_data_out,
  output logic [1:0] rd_last_out,
  input wire logic [1:0] rd_ready_in
);

  cfxp_state_t st; // registered state
  cfxp_state_t next_st; // next state
  logic [1:0][7:0] elig; // queues that may be served per port
  logic [1:0][2:0] pick; // scheduler choice per port
  logic [1:0] any; // scheduler has a candidate
  logic [1:0] take; // a grant is issued this cycle
  logic [1:0] out_free; // output slot can take a word this cycle
  cfxp_hdr_t [1:0] hdr_new; // header built from the side-band
  logic [1:0][14:0] len_total; // byte length plus bias

  ////////////////////////////////////////////////////////////////////////
  // queue eligibility: a queue belongs to the port its map bit names
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      for (int q = 0; q < 8; q++) begin
        elig[p][q] = q_nonempty_in[q] && (st.map[q] == 1'(p));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one scheduler per cpu port
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_sched
      cfxp_sched u_sched (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .req_in(elig[gp]),
        .rr_mode_in(st.rr_mode[gp]),
        .take_in(take[gp]),
        .pick_out(pick[gp]),
        .any_out(any[gp])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // build the extraction header from the side-band of each port
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      hdr_new[p] = '0;
      len_total[p] = 15'(meta_in[p].byte_len) + `CFXP_LEN_BIAS;
      // rewrite operation: two-step carries the timestamp id above the code
      if (meta_in[p].two_step) begin
        hdr_new[p].rewrite_op_code = {meta_in[p].ts_id, `CFXP_OP_TWO_STEP};
      end
      hdr_new[p].rx_time_value = meta_in[p].rx_time;
      // words of 60 bytes plus a remainder, offset by the bias
      hdr_new[p].length_word_count = 8'(len_total[p] / `CFXP_LEN_UNIT);
      hdr_new[p].length_remainder = 6'(len_total[p] % `CFXP_LEN_UNIT);
      hdr_new[p].ingress_port_number = meta_in[p].ingress_port_number;
      hdr_new[p].rule_hit_flag = meta_in[p].copy_to_host_action
        | meta_in[p].copy_once_action;
      // the action id means something only on a hit
      if (hdr_new[p].rule_hit_flag) begin
        hdr_new[p].rule_action_id = meta_in[p].rule_action_id;
      end
      // reserved sample codes are reported as not sampled
      if (meta_in[p].sample_origin_id == `CFXP_SMP_RSV_LO
          || meta_in[p].sample_origin_id == `CFXP_SMP_RSV_HI) begin
        hdr_new[p].sample_origin_id = `CFXP_SMP_NONE;
      end else begin
        hdr_new[p].sample_origin_id = meta_in[p].sample_origin_id;
      end
      hdr_new[p].drop_level = meta_in[p].drop_level;
      hdr_new[p].learn_action_code = meta_in[p].learn_action_code;
      // the granted queue is always part of the mask
      hdr_new[p].queue_hit_mask = meta_in[p].queue_hit_mask
        | (8'h01 << st.port[p].grant_q);
      hdr_new[p].service_class = meta_in[p].service_class;
      hdr_new[p].tag_type = (meta_in[p].tpid != `CFXP_TPID_CTAG);
      hdr_new[p].tag_priority = meta_in[p].tag_priority;
      hdr_new[p].drop_eligible = meta_in[p].drop_eligible;
      hdr_new[p].vlan_number = meta_in[p].vlan_number;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: register port and per-port frame flow
  always_comb begin
    next_st = st;
    take = 2'h0;
    out_free = 2'h0;
    next_st.rdata = 32'h0000_0000;
    // register writes
    if (reg_wr_in) begin
      if (reg_addr_in == `CFXP_REG_MAP) begin
        next_st.map = reg_wdata_in[7:0];
      end else if (reg_addr_in == `CFXP_REG_CFG) begin
        next_st.hdr_en = reg_wdata_in[`CFXP_CFG_HDR_LSB +: 2];
        next_st.rr_mode = reg_wdata_in[`CFXP_CFG_RR_LSB +: 2];
      end
    end
    // register reads, answered in the next cycle; unmapped reads zero
    if (reg_rd_in) begin
      if (reg_addr_in == `CFXP_REG_MAP) begin
        next_st.rdata[7:0] = st.map;
      end else if (reg_addr_in == `CFXP_REG_CFG) begin
        next_st.rdata[`CFXP_CFG_HDR_LSB +: 2] = st.hdr_en;
        next_st.rdata[`CFXP_CFG_RR_LSB +: 2] = st.rr_mode;
      end else if (reg_addr_in == `CFXP_REG_STAT) begin
        next_st.rdata[7:0] = {st.port[0].out_valid, st.port[0].core_ready,
                              st.port[0].cnt, st.port[0].fsm};
        next_st.rdata[`CFXP_STAT_P1_LSB +: 8] = {st.port[1].out_valid,
                              st.port[1].core_ready, st.port[1].cnt, st.port[1].fsm};
      end
    end
    for (int p = 0; p < 2; p++) begin
      next_st.port[p].grant = 1'b0;
      // the reader takes the held word
      if (st.port[p].out_valid && rd_ready_in[p]) begin
        next_st.port[p].out_valid = 1'b0;
        next_st.port[p].out_last = 1'b0;
      end
      out_free[p] = !st.port[p].out_valid || rd_ready_in[p];
      case (st.port[p].fsm)
        // pick a queue and tell the core to send its head frame
        CFXP_S_IDLE: begin
          if (any[p]) begin
            take[p] = 1'b1;
            next_st.port[p].grant = 1'b1;
            next_st.port[p].grant_q = pick[p];
            next_st.port[p].fsm = CFXP_S_META;
          end
        end
        // wait for the side-band, then header or straight to data
        CFXP_S_META: begin
          if (meta_valid_in[p]) begin
            next_st.port[p].hdr = hdr_new[p];
            next_st.port[p].cnt = 2'h0;
            if (st.hdr_en[p]) begin
              next_st.port[p].fsm = CFXP_S_HDR;
            end else begin
              next_st.port[p].fsm = CFXP_S_DATA;
            end
          end
        end
        // four header words, most significant first
        CFXP_S_HDR: begin
          if (out_free[p]) begin
            next_st.port[p].out_data = st.port[p].hdr[127:96];
            next_st.port[p].out_valid = 1'b1;
            next_st.port[p].out_last = 1'b0;
            next_st.port[p].hdr = {st.port[p].hdr[95:0], 32'h0000_0000};
            next_st.port[p].cnt = 2'(st.port[p].cnt + 2'h1);
            if (st.port[p].cnt == `CFXP_HDR_LAST) begin
              next_st.port[p].fsm = CFXP_S_DATA;
            end
          end
        end
        // pass frame words through the single output slot
        CFXP_S_DATA: begin
          if (st.port[p].core_ready && core_valid_in[p]) begin
            next_st.port[p].out_data = core_data_in[p];
            next_st.port[p].out_valid = 1'b1;
            next_st.port[p].out_last = core_last_in[p];
            if (core_last_in[p]) begin
              next_st.port[p].fsm = CFXP_S_IDLE;
            end
          end
        end
        default: begin
          next_st.port[p].fsm = CFXP_S_IDLE;
        end
      endcase
      // accept a core word next cycle only if the slot is empty then
      next_st.port[p].core_ready = (next_st.port[p].fsm == CFXP_S_DATA)
        && !next_st.port[p].out_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register the state; control state starts idle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.map <= `CFXP_MAP_RST;
      st.hdr_en <= `CFXP_HDR_EN_RST;
      st.rr_mode <= `CFXP_RR_RST;
      st.port[0].fsm <= CFXP_S_IDLE;
      st.port[1].fsm <= CFXP_S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  always_comb begin
    reg_rdata_out = st.rdata;
    for (int p = 0; p < 2; p++) begin
      grant_out[p] = st.port[p].grant;
      grant_queue_out[p] = st.port[p].grant_q;
      core_ready_out[p] = st.port[p].core_ready;
      rd_valid_out[p] = st.port[p].out_valid;
      rd_data_out[p] = st.port[p].out_data;
      rd_last_out[p] = st.port[p].out_last;
    end
  end

endmodule : cfxp_top

`default_nettype wire

// ### sim/cfxp_rdr.sv
// reader model: the host side taking extracted words of one cpu port
// assumes words are offered with a valid and held until ready is seen
`timescale 1ns/1ns
`default_nettype none
module cfxp_rdr (
  input wire logic ref_clk_in,
  input wire logic stall_in,
  input wire logic rd_valid_in,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_last_in,
  output logic rd_ready_out
);
  logic [32:0] words [$]; // accepted words, frame end flag on top
  initial rd_ready_out = 1'b0;
  // take a word on each edge with valid and ready, stall halves the rate
  always @(posedge ref_clk_in) begin
    if (rd_valid_in === 1'b1 && rd_ready_out) begin
      words.push_back({rd_last_in, rd_data_in});
    end
    rd_ready_out <= stall_in ? ~rd_ready_out : 1'b1;
  end
endmodule : cfxp_rdr
`default_nettype wire

// ### sim/cfxp_chk.sv
// checker: grant choice, word hand-over and register port of cfxp_top
// assumes it is bound to cfxp_top; index 0 is port 11
`timescale 1ns/1ns
`default_nettype none
`include "cfxp_defs.svh"
module cfxp_chk (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [7:0] q_nonempty_in,
  input wire logic [1:0] grant_out,
  input wire logic [1:0][2:0] grant_queue_out,
  input wire logic [1:0] core_valid_in,
  input wire logic [1:0][31:0] core_data_in,
  input wire logic [1:0] core_last_in,
  input wire logic [1:0] core_ready_out,
  input wire logic [1:0] rd_valid_out,
  input wire logic [1:0][31:0] rd_data_out,
  input wire logic [1:0] rd_last_out,
  input wire logic [1:0] rd_ready_in
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [7:0] map_m; // mirrored queue map
  logic [1:0] rr_m; // mirrored round robin enables
  logic [7:0] q_prev; // queue status at the deciding edge
  logic [1:0][2:0] last_m; // last granted queue per port
  // mirror the settings and the grant history
  always_ff @(posedge ref_clk_in) begin
    q_prev <= q_nonempty_in;
    if (!rst_n_in) begin
      map_m <= 8'h00;
      rr_m <= 2'h0;
      last_m <= 6'h00;
    end else begin
      if (reg_wr_in && reg_addr_in == `CFXP_REG_MAP) begin
        map_m <= reg_wdata_in[7:0];
      end
      if (reg_wr_in && reg_addr_in == `CFXP_REG_CFG) begin
        rr_m <= reg_wdata_in[9:8];
      end
      for (int p = 0; p < 2; p++) begin
        if (grant_out[p]) begin
          last_m[p] <= grant_queue_out[p];
        end
      end
    end
  end
  // queue that should win: highest, or first one after l
  function automatic logic [2:0] pick(input logic [7:0] m, input logic rr, input logic [2:0] l);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (!rr && m[i]) begin
        r = 3'(i);
      end
      if (rr && m[3'(int'(l) + 8 - i)]) begin
        r = 3'(int'(l) + 8 - i);
      end
    end
    return r;
  endfunction : pick
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] elig; // queues this port may serve
    assign elig = q_prev & ((p == 0) ? ~map_m : map_m);
    grant_pulse_a: assert property (grant_out[p] |=> !grant_out[p] [*2])
      else $error("grant pulse too long");
    grant_mapped_a: assert property (grant_out[p] |-> elig[grant_queue_out[p]])
      else $error("granted queue not eligible here");
    strict_pick_a: assert property (grant_out[p] && !rr_m[p] |->
      grant_queue_out[p] == pick(elig, 1'b0, 3'h0)) else $error("strict grant not highest");
    rr_pick_a: assert property (grant_out[p] && rr_m[p] |->
      grant_queue_out[p] == pick(elig, 1'b1, last_m[p])) else $error("round robin out of turn");
    take_answer_a: assert property (core_valid_in[p] && core_ready_out[p] |=>
      rd_valid_out[p] && !core_ready_out[p] && rd_data_out[p] == $past(core_data_in[p])
      && rd_last_out[p] == $past(core_last_in[p])) else $error("taken word not passed on");
    rd_hold_a: assert property (rd_valid_out[p] && !rd_ready_in[p] |=> rd_valid_out[p]
      && $stable(rd_data_out[p]) && $stable(rd_last_out[p])) else $error("word not held");
  end
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h00000000)
    else $error("read data outside answer cycle");
  map_readback_a: assert property (reg_wr_in && reg_addr_in == `CFXP_REG_MAP ##1
    reg_rd_in && reg_addr_in == `CFXP_REG_MAP |=>
    reg_rdata_out == {24'h000000, $past(reg_wdata_in[7:0], 2)}) else $error("map readback");
  rr_seen_c: cover property (grant_out[0] && rr_m[0]);
  stall_seen_c: cover property (rd_valid_out[0] && !rd_ready_in[0]);
  end_seen_c: cover property (rd_valid_out[1] && rd_last_out[1] && rd_ready_in[1]);
endmodule : cfxp_chk
bind cfxp_top cfxp_chk chk_u (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .q_nonempty_in, .grant_out, .grant_queue_out,
  .core_valid_in, .core_data_in, .core_last_in, .core_ready_out, .rd_valid_out,
  .rd_data_out, .rd_last_out, .rd_ready_in);
`default_nettype wire

// ### sim/tb.sv
// bench of cfxp_top: registers, both schedulers, header insertion
// assumes the bench plays the switch core and two reader models
`timescale 1ns/1ns
`default_nettype none
`include "cfxp_defs.svh"
module tb
  import cfxp_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] q_ne = 8'h00;
  logic [1:0] gnt;
  logic [1:0][2:0] gq;
  logic [1:0] mv = 2'h0;
  cfxp_meta_t [1:0] md = '0;
  logic [1:0] cv = 2'h0;
  logic [1:0][31:0] cd = 64'h0;
  logic [1:0] cl = 2'h0;
  logic [1:0] cr;
  logic [1:0] rv;
  logic [1:0][31:0] rdat;
  logic [1:0] rl;
  logic [1:0] rr;
  logic [1:0] stall = 2'h0;
  int bad_count;
  int checked;
  int cyc;
  int gcnt[2];
  int gtook[2];
  cfxp_top dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .q_nonempty_in(q_ne), .grant_out(gnt), .grant_queue_out(gq), .meta_valid_in(mv),
    .meta_in(md), .core_valid_in(cv), .core_data_in(cd), .core_last_in(cl),
    .core_ready_out(cr), .rd_valid_out(rv), .rd_data_out(rdat), .rd_last_out(rl),
    .rd_ready_in(rr));
  cfxp_rdr rdr0 (.ref_clk_in(ref_clk_in), .stall_in(stall[0]), .rd_valid_in(rv[0]),
    .rd_data_in(rdat[0]), .rd_last_in(rl[0]), .rd_ready_out(rr[0]));
  cfxp_rdr rdr1 (.ref_clk_in(ref_clk_in), .stall_in(stall[1]), .rd_valid_in(rv[1]),
    .rd_data_in(rdat[1]), .rd_last_in(rl[1]), .rd_ready_out(rr[1]));
  always #2 ref_clk_in = ~ref_clk_in;
  // count grants and cut a hang short
  always @(posedge ref_clk_in) begin
    cyc++;
    for (int p = 0; p < 2; p++) begin
      if (gnt[p] === 1'b1) begin
        gcnt[p]++;
      end
    end
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // write one place, read another in the very next cycle
  task access(input logic [7:0] wa, input logic [31:0] d, input logic [7:0] ra,
              input logic [31:0] e);
    @(posedge ref_clk_in);
    wr <= 1'b1;
    addr <= wa;
    wdata <= d;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= ra;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(negedge ref_clk_in);
    check({1'b0, rdata}, {1'b0, e});
  endtask : access
  task wait_grant(input int p, input logic [2:0] e);
    int t;
    t = 0;
    while (gcnt[p] == gtook[p] && t < 100) begin
      @(negedge ref_clk_in);
      t++;
    end
    gtook[p]++;
    bad_count += (t == 100); // a grant that never came fails the run
    check({30'h0, gq[p]}, {30'h0, e});
  endtask : wait_grant
  // core side: side-band, then n words; queue status updated as last goes
  task frame(input int p, input cfxp_meta_t m, input int n, input logic [7:0] q_after);
    int t;
    @(posedge ref_clk_in);
    mv[p] <= 1'b1;
    md[p] <= m;
    @(posedge ref_clk_in);
    mv[p] <= 1'b0;
    for (int k = 0; k < n; k++) begin
      cv[p] <= 1'b1;
      cd[p] <= {8'h5A, 8'(p), 8'(n), 8'(k)};
      cl[p] <= (k == n - 1);
      t = 0;
      do begin
        @(posedge ref_clk_in);
        t++;
      end while (cr[p] !== 1'b1 && t < 100);
    end
    cv[p] <= 1'b0;
    cl[p] <= 1'b0;
    q_ne <= q_after;
  endtask : frame
  task pull(input int p, output logic [32:0] w);
    int t;
    t = 0;
    while ((p ? rdr1.words.size() : rdr0.words.size()) == 0 && t < 200) begin
      @(negedge ref_clk_in);
      t++;
    end
    w = p ? rdr1.words.pop_front() : rdr0.words.pop_front();
  endtask : pull
  task expect_frame(input int p, input int n);
    logic [32:0] w;
    for (int k = 0; k < n; k++) begin
      pull(p, w);
      check(w, {k == n - 1, 8'h5A, 8'(p), 8'(n), 8'(k)});
    end
  endtask : expect_frame
  // header built bit by bit; untouched positions stay zero
  function automatic logic [127:0] hdr_exp(input cfxp_meta_t m, input logic [2:0] q);
    logic [127:0] h;
    logic [14:0] tot;
    h = 128'h0;
    tot = 15'(m.byte_len) + 15'h0050;
    if (m.two_step) begin
      h[125:117] = {m.ts_id, 3'h3};
    end
    h[116:85] = m.rx_time;
    h[84:79] = 6'(tot % 15'h003C);
    h[78:71] = 8'(tot / 15'h003C);
    h[46:43] = m.ingress_port_number;
    h[31] = m.copy_to_host_action | m.copy_once_action;
    h[42:37] = h[31] ? m.rule_action_id : 6'h00;
    h[35:32] = (m.sample_origin_id inside {4'hD, 4'hE}) ? 4'hF : m.sample_origin_id;
    h[30] = m.drop_level;
    h[29:28] = m.learn_action_code;
    h[27:20] = m.queue_hit_mask | (8'h01 << q);
    h[19:17] = m.service_class;
    h[16] = (m.tpid != 16'h8100);
    h[15:0] = {m.tag_priority, m.drop_eligible, m.vlan_number};
    return h;
  endfunction : hdr_exp
  task sc_regs();
    access(8'h0C, 32'hFFFFFFFF, `CFXP_REG_CFG, 32'h0);
    access(`CFXP_REG_MAP, 32'hFFFFFFA5, `CFXP_REG_MAP, 32'hA5);
    access(`CFXP_REG_CFG, 32'hFFFFFFFF, 8'h0C, 32'h0);
    access(`CFXP_REG_MAP, 32'h0, `CFXP_REG_CFG, 32'h0303);
    access(`CFXP_REG_CFG, 32'h0, `CFXP_REG_STAT, 32'h0101);
  endtask : sc_regs
  task sc_strict();
    access(`CFXP_REG_MAP, 32'h81, `CFXP_REG_MAP, 32'h81);
    @(posedge ref_clk_in);
    q_ne <= 8'hC3;
    wait_grant(0, 3'h6);
    wait_grant(1, 3'h7);
    frame(0, '0, 2, 8'h83);
    expect_frame(0, 2);
    wait_grant(0, 3'h1);
    frame(1, '0, 1, 8'h03);
    expect_frame(1, 1);
    wait_grant(1, 3'h0);
    frame(0, '0, 3, 8'h01);
    expect_frame(0, 3);
    frame(1, '0, 2, 8'h00);
    expect_frame(1, 2);
  endtask : sc_strict
  task sc_rr();
    static logic [2:0] seq [4] = '{3'h2, 3'h5, 3'h0, 3'h2};
    access(`CFXP_REG_MAP, 32'h0, `CFXP_REG_MAP, 32'h0);
    access(`CFXP_REG_CFG, 32'h100, `CFXP_REG_CFG, 32'h100);
    @(posedge ref_clk_in);
    q_ne <= 8'h25;
    for (int i = 0; i < 4; i++) begin
      wait_grant(0, seq[i]);
      frame(0, '0, 1, (i == 3) ? 8'h00 : 8'h25);
      expect_frame(0, 1);
    end
  endtask : sc_rr
  task sc_header();
    cfxp_meta_t m;
    logic [32:0] w;
    logic [127:0] h;
    int p;
    static logic [3:0] smp [4] = '{4'h3, 4'hC, 4'hD, 4'hF};
    static logic [15:0] tp [4] = '{16'h8100, 16'h88A8, 16'h8100, 16'h9100};
    access(`CFXP_REG_CFG, 32'h3, `CFXP_REG_CFG, 32'h3);
    @(posedge ref_clk_in);
    stall <= 2'h3;
    for (int k = 0; k < 4; k++) begin
      p = k / 2;
      // two frames on port 11, then queue 4 moves over to port 12
      if (k == 2) begin
        access(`CFXP_REG_MAP, 32'h10, `CFXP_REG_MAP, 32'h10);
      end
      if (!k[0]) begin
        @(posedge ref_clk_in);
        q_ne <= 8'h10;
      end
      m = '0;
      m.two_step = k[0];
      m.ts_id = 6'h15 + 6'(k);
      m.rx_time = 32'hC0DE0000 + 32'(k);
      m.byte_len = 14'h0040 + 14'(k * 77);
      m.ingress_port_number = 4'hB - 4'(k);
      m.rule_action_id = 6'h3F - 6'(k);
      m.sample_origin_id = smp[k];
      m.copy_to_host_action = (k == 1);
      m.copy_once_action = (k == 2);
      m.drop_level = k[1];
      m.learn_action_code = 2'(k);
      m.queue_hit_mask = 8'h81;
      m.service_class = 3'(k + 3);
      m.tpid = tp[k];
      m.tag_priority = 3'(k + 5);
      m.drop_eligible = k[0];
      m.vlan_number = 12'hABC - 12'(k);
      wait_grant(p, 3'h4);
      frame(p, m, 3, k[0] ? 8'h00 : 8'h10);
      h = hdr_exp(m, 3'h4);
      for (int i = 0; i < 4; i++) begin
        pull(p, w);
        check(w, {1'b0, h[127 - 32 * i -: 32]});
      end
      expect_frame(p, 3);
    end
  endtask : sc_header
  task print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    sc_regs();
    sc_strict();
    sc_rr();
    sc_header();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
